/* design/atsb_top.sv */
// Overview of operation
// - thirty-two tone generators each hold their own settings.
// - a setting of one generator reaches every channel fed by it.
// - a muted generator delivers zero samples.
// - frequency spans 10 Hz to 20000 Hz in half-hertz steps.
// - amplitude spans -60 dB to 0 dB in 1 dB steps.
// - with click on, each period ends in 250 ms of silence.
// - the click period is one, two, three or four seconds.
// - with click off the tone runs without any gap.
// - each generator carries a four-character origin tag.
// - each of four outputs takes sixteen embedded channels.
// - any generator may feed any number of channels.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "atsb_defs.svh"
module atsb_top #(
    parameter int SAMPLE_DIV = `ATSB_CLK_HZ / `ATSB_SAMPLE_HZ
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire atsb_pkg::atsb_addr_t S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire atsb_pkg::atsb_word_t S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire atsb_pkg::atsb_addr_t S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output atsb_pkg::atsb_word_t S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic EMB_VALID,
    output logic [1:0] EMB_OUTPUT,
    output logic [3:0] EMB_CHANNEL,
    output logic [4:0] EMB_SOURCE,
    output atsb_pkg::atsb_sample_t EMB_SAMPLE,
    output atsb_pkg::atsb_word_t EMB_ORIGIN
);
    import atsb_pkg::*;

    // ---------------------------------------------------------------
    // settings
    // ---------------------------------------------------------------
    logic [15:0] freq [`ATSB_NUM_GEN];
    logic [5:0] atten [`ATSB_NUM_GEN];
    logic [3:0] ctrl [`ATSB_NUM_GEN];
    atsb_word_t channel_origin_tag [`ATSB_NUM_GEN];
    logic [4:0] route [`ATSB_NUM_ROUTE];
    logic [31:0] phase [`ATSB_NUM_GEN];
    logic [17:0] click_cnt [`ATSB_NUM_GEN];
    atsb_sample_t gen_sample [`ATSB_NUM_GEN];
    logic [31:0] silent;
    logic [31:0] sample_count;

    function automatic atsb_word_t reg_read(input atsb_addr_t a);
        logic [4:0] g;
        g = a[8:4];
        reg_read = 32'h0;
        if (a[11:9] == `ATSB_GEN_TOP) begin
            case (a[3:2])
                `ATSB_FLD_FREQ: reg_read = {16'h0, freq[g]};
                `ATSB_FLD_ATTEN: reg_read = {26'h0, atten[g]};
                `ATSB_FLD_CTRL: reg_read = {28'h0, ctrl[g]};
                default: reg_read = channel_origin_tag[g];
            endcase
        end else if (a[11:8] == `ATSB_ROUTE_TOP) begin
            reg_read = {27'h0, route[a[7:2]]};
        end else if (a == `ATSB_STATUS_ADDR) begin
            reg_read = silent;
        end else if (a == `ATSB_COUNT_ADDR) begin
            reg_read = sample_count;
        end
    endfunction

    function automatic logic reg_hit(input atsb_addr_t a);
        reg_hit = a[11:9] == `ATSB_GEN_TOP || a[11:8] == `ATSB_ROUTE_TOP
            || a == `ATSB_STATUS_ADDR || a == `ATSB_COUNT_ADDR;
    endfunction

    // ---------------------------------------------------------------
    // axi4-lite write channel
    // ---------------------------------------------------------------
    logic aw_held, w_held, do_write;
    atsb_addr_t aw_addr;
    atsb_word_t w_data, merged;
    logic [3:0] w_strb;
    assign do_write = aw_held && w_held && !S_AXI_BVALID;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `ATSB_RESP_OKAY;
            aw_addr <= 12'h000;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (do_write) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= reg_hit(aw_addr) ? `ATSB_RESP_OKAY
                                                : `ATSB_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    always_comb begin
        merged = reg_read(aw_addr);
        for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
                merged[b*8 +: 8] = w_data[b*8 +: 8];
            end
        end
    end

    // ---------------------------------------------------------------
    // setting registers
    // ---------------------------------------------------------------
    // out-of-range values clamp rather than fault, so a tone never stops
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int g = 0; g < `ATSB_NUM_GEN; g++) begin
                freq[g] <= `ATSB_FREQ_RST;
                atten[g] <= `ATSB_ATTEN_RST;
                ctrl[g] <= `ATSB_CTRL_RST;
                channel_origin_tag[g] <= `ATSB_ORIGIN_RST;
            end
            for (int r = 0; r < `ATSB_NUM_ROUTE; r++) begin
                route[r] <= `ATSB_ROUTE_RST;
            end
        end else if (do_write) begin
            if (aw_addr[11:9] == `ATSB_GEN_TOP) begin
                case (aw_addr[3:2])
                    `ATSB_FLD_FREQ: begin
                        if (merged[15:0] < `ATSB_FREQ_MIN) begin
                            freq[aw_addr[8:4]] <= `ATSB_FREQ_MIN;
                        end else if (merged[15:0] > `ATSB_FREQ_MAX
                                     || merged[31:16] != 16'h0) begin
                            freq[aw_addr[8:4]] <= `ATSB_FREQ_MAX;
                        end else begin
                            freq[aw_addr[8:4]] <= merged[15:0];
                        end
                    end
                    `ATSB_FLD_ATTEN: begin
                        if (merged[5:0] > `ATSB_ATTEN_MAX
                            || merged[31:6] != 26'h0) begin
                            atten[aw_addr[8:4]] <= `ATSB_ATTEN_MAX;
                        end else begin
                            atten[aw_addr[8:4]] <= merged[5:0];
                        end
                    end
                    `ATSB_FLD_CTRL: ctrl[aw_addr[8:4]] <= merged[3:0];
                    default: channel_origin_tag[aw_addr[8:4]] <= merged;
                endcase
            end else if (aw_addr[11:8] == `ATSB_ROUTE_TOP) begin
                route[aw_addr[7:2]] <= merged[4:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read channel
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `ATSB_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= reg_read(S_AXI_ARADDR);
            S_AXI_RRESP <= reg_hit(S_AXI_ARADDR) ? `ATSB_RESP_OKAY
                                                 : `ATSB_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // sample rate divider and sequencer
    // ---------------------------------------------------------------
    logic [15:0] div_cnt;
    logic sample_en;
    atsb_state_t state;
    logic [4:0] gi;
    logic [5:0] ci;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            div_cnt <= 16'h0;
            sample_en <= 1'b0;
        end else begin
            sample_en <= div_cnt == 16'(SAMPLE_DIV - 1);
            div_cnt <= (div_cnt == 16'(SAMPLE_DIV - 1)) ? 16'h0
                                                        : div_cnt + 16'h1;
        end
    end

    // generators share one datapath: 32 cycles of compute, 64 of send
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= ATSB_IDLE;
            gi <= 5'h0;
            ci <= 6'h0;
            sample_count <= 32'h0;
        end else begin
            case (state)
                ATSB_IDLE: if (sample_en) begin
                    state <= ATSB_CALC;
                    gi <= 5'h0;
                    sample_count <= sample_count + 32'h1;
                end
                ATSB_CALC: begin
                    gi <= gi + 5'h1;
                    if (gi == 5'h1F) begin
                        state <= ATSB_SEND;
                        ci <= 6'h0;
                    end
                end
                ATSB_SEND: begin
                    ci <= ci + 6'h1;
                    if (ci == 6'h3F) begin
                        state <= ATSB_IDLE;
                    end
                end
                default: state <= ATSB_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // tone datapath for generator gi
    // ---------------------------------------------------------------
    function automatic logic [16:0] gain_of(input logic [5:0] db);
        logic [16:0] base;
        case (db % 6'h06)
            6'h00: base = 17'h10000;
            6'h01: base = 17'h0E429;
            6'h02: base = 17'h0CB59;
            6'h03: base = 17'h0B53C;
            6'h04: base = 17'h0A186;
            default: base = 17'h08FF6;
        endcase
        gain_of = base >> (db / 6'h06);
    endfunction

    logic signed [16:0] xs;
    logic [16:0] mag;
    logic signed [34:0] prod;
    logic signed [29:0] wave;
    atsb_sample_t wave_sat, scaled, gated;
    logic signed [41:0] amp_prod;
    logic [31:0] inc;
    logic [17:0] period, cnt;
    logic in_gap, click_on, mute_on;

    always_comb begin
        xs = {phase[gi][31], phase[gi][31:16]};
        mag = 17'h08000 - (xs < 0 ? 17'(-xs) : 17'(xs));
        // parabola sine: cheap, no table, roughly 3.7 % third harmonic
        prod = 35'(xs * $signed({1'b0, mag}));
        wave = 30'(prod >>> 5);
        if (wave > 30'sh007FFFFF) begin
            wave_sat = 24'h7FFFFF;
        end else if (wave < -30'sh007FFFFF) begin
            wave_sat = 24'h800001;
        end else begin
            wave_sat = wave[23:0];
        end
        amp_prod = 42'($signed(wave_sat)
                   * $signed({1'b0, gain_of(atten[gi])}));
        scaled = amp_prod[39:16];
        inc = 32'(freq[gi]) * 32'(`ATSB_PHASE_STEP);
        click_on = ctrl[gi][`ATSB_CTRL_CLICK];
        mute_on = ctrl[gi][`ATSB_CTRL_MUTE];
        cnt = click_cnt[gi];
        period = 18'(`ATSB_SAMPLE_HZ) * (18'h1 + 18'(ctrl[gi][
                 `ATSB_CTRL_PER_MSB:`ATSB_CTRL_PER_LSB]));
        in_gap = click_on
                 && cnt >= period - 18'(`ATSB_MUTE_SAMPLES);
        gated = (mute_on || in_gap) ? 24'h0 : scaled;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int g = 0; g < `ATSB_NUM_GEN; g++) begin
                phase[g] <= 32'h0;
                click_cnt[g] <= 18'h0;
                gen_sample[g] <= 24'h0;
            end
            silent <= 32'h0;
        end else if (state == ATSB_CALC) begin
            phase[gi] <= phase[gi] + inc;
            gen_sample[gi] <= gated;
            silent[gi] <= mute_on || in_gap;
            if (!click_on || cnt >= period - 18'h1) begin
                click_cnt[gi] <= 18'h0;
            end else begin
                click_cnt[gi] <= cnt + 18'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // embedder feed
    // ---------------------------------------------------------------
    logic [4:0] src;
    assign src = route[ci];

    // samples are read live from the shared store, so every channel on
    // the same generator sees a setting change in the same sample
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            EMB_VALID <= 1'b0;
            EMB_OUTPUT <= 2'h0;
            EMB_CHANNEL <= 4'h0;
            EMB_SOURCE <= 5'h0;
            EMB_SAMPLE <= 24'h0;
            EMB_ORIGIN <= 32'h0;
        end else begin
            EMB_VALID <= state == ATSB_SEND;
            EMB_OUTPUT <= ci[5:4];
            EMB_CHANNEL <= ci[3:0];
            EMB_SOURCE <= src;
            EMB_SAMPLE <= gen_sample[src];
            EMB_ORIGIN <= channel_origin_tag[src];
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    calc_span_a: assert property (
        state == ATSB_IDLE && sample_en |-> ##1 (state == ATSB_CALC)[*8]
        ##24 state == ATSB_CALC ##1 state == ATSB_SEND)
        else $error("compute pass is not 32 cycles");
    send_span_a: assert property (
        $rose(state == ATSB_SEND) |-> ##1 EMB_VALID[*8] ##56 EMB_VALID
        ##1 !EMB_VALID)
        else $error("feed pass is not 64 channels");
    mute_zero_a: assert property (
        state == ATSB_CALC && mute_on |=> gen_sample[$past(gi)] == 24'h0)
        else $error("muted generator gave a nonzero sample");
    click_gap_a: assert property (
        state == ATSB_CALC && in_gap |=> gen_sample[$past(gi)] == 24'h0
        && silent[$past(gi)])
        else $error("click gap not silent");
    click_wrap_a: assert property (
        state == ATSB_CALC && click_on && cnt == period - 18'h1
        |=> click_cnt[$past(gi)] == 18'h0)
        else $error("click period did not wrap");
    click_off_a: assert property (
        state == ATSB_CALC && !click_on && !mute_on
        |=> gen_sample[$past(gi)] == $past(scaled) && !silent[$past(gi)])
        else $error("tone interrupted with click off");
    phase_step_a: assert property (
        state == ATSB_CALC
        |=> phase[$past(gi)] == $past(phase[gi]) + $past(inc))
        else $error("phase did not advance by the step");
    route_feed_a: assert property (
        state == ATSB_SEND |=> EMB_SOURCE == $past(src)
        && EMB_SAMPLE == gen_sample[EMB_SOURCE])
        else $error("channel fed from the wrong generator");
    origin_feed_a: assert property (
        state == ATSB_SEND |=> EMB_ORIGIN == $past(channel_origin_tag[src]))
        else $error("origin tag does not follow its generator");
endmodule

/* design/atsb_defs.svh */
`ifndef ATSB_DEFS_SVH
`define ATSB_DEFS_SVH
// ---------------------------------------------------------------
// sizes and timing
// ---------------------------------------------------------------
`define ATSB_NUM_GEN 32
`define ATSB_NUM_ROUTE 64
`define ATSB_CLK_HZ 200000000
`define ATSB_SAMPLE_HZ 48000
`define ATSB_CLICK_MUTE_MS 250
`define ATSB_MUTE_SAMPLES \
    ((`ATSB_CLICK_MUTE_MS * `ATSB_SAMPLE_HZ) / 1000)
// frequency in half-hertz units, phase step is 2^32 / (2 * 48000)
`define ATSB_FREQ_MIN 16'h0014
`define ATSB_FREQ_MAX 16'h9C40
`define ATSB_PHASE_STEP 16'hAEC3
`define ATSB_ATTEN_MAX 6'h3C
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define ATSB_GEN_TOP 3'h0
`define ATSB_FLD_FREQ 2'h0
`define ATSB_FLD_ATTEN 2'h1
`define ATSB_FLD_CTRL 2'h2
`define ATSB_FLD_ORIGIN 2'h3
`define ATSB_ROUTE_TOP 4'h2
`define ATSB_STATUS_ADDR 12'h300
`define ATSB_COUNT_ADDR 12'h304
`define ATSB_CTRL_MUTE 0
`define ATSB_CTRL_CLICK 1
`define ATSB_CTRL_PER_LSB 2
`define ATSB_CTRL_PER_MSB 3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ATSB_FREQ_RST 16'h07D0
`define ATSB_ATTEN_RST 6'h14
`define ATSB_CTRL_RST 4'h0
`define ATSB_ORIGIN_RST 32'h20202020
`define ATSB_ROUTE_RST 5'h00
`define ATSB_RESP_OKAY 2'h0
`define ATSB_RESP_SLVERR 2'h2
`endif

/* design/atsb_pkg.sv */
package atsb_pkg;
    typedef enum logic [1:0] {ATSB_IDLE, ATSB_CALC, ATSB_SEND} atsb_state_t;
    typedef logic [23:0] atsb_sample_t;
    typedef logic [31:0] atsb_word_t;
    typedef logic [11:0] atsb_addr_t;
endpackage

/* bench/atsb_sink.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// embedder side: takes every item, it has no way to stall
// ---------------------------------------------------------------
module atsb_sink (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic emb_valid,
    input wire logic [1:0] emb_output,
    input wire logic [3:0] emb_channel,
    input wire logic [4:0] emb_source,
    input wire atsb_pkg::atsb_sample_t emb_sample,
    input wire atsb_pkg::atsb_word_t emb_origin
);
    import atsb_pkg::*;
    logic [4:0] src [64];
    atsb_sample_t smp [64];
    atsb_word_t org [64];
    logic [5:0] exp_ci;
    int passes;
    int bad;
    // last item of each channel is kept so the bench can look back
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            exp_ci <= 6'h00;
            passes <= 0;
            bad <= 0;
        end else if (emb_valid) begin
            src[{emb_output, emb_channel}] <= emb_source;
            smp[{emb_output, emb_channel}] <= emb_sample;
            org[{emb_output, emb_channel}] <= emb_origin;
            if ({emb_output, emb_channel} != exp_ci) begin
                bad <= bad + 1;
            end
            exp_ci <= exp_ci + 6'h01;
            if (exp_ci == 6'h3F) begin
                passes <= passes + 1;
            end
        end
    end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "atsb_defs.svh"
module testbench;
    import atsb_pkg::*;
    // short sample period keeps the run small; click gaps stay out of reach
    localparam int DIV = 100;
    localparam logic [1:0] OK = `ATSB_RESP_OKAY;
    localparam logic [1:0] ERR = `ATSB_RESP_SLVERR;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    atsb_addr_t awaddr = '0;
    atsb_addr_t araddr = '0;
    atsb_word_t wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, ev;
    logic [1:0] bresp, rresp, eo;
    logic [3:0] ec;
    logic [4:0] es;
    atsb_sample_t esmp;
    atsb_word_t rdata, eorg, seed;
    int miscompares = 0;
    int checks_done = 0;
    logic [1:0] route [64];
    atsb_word_t freq [32];
    always #2.5 clk_sys = ~clk_sys;
    atsb_top #(.SAMPLE_DIV(DIV)) dut (
        .CLK_SYS(clk_sys), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .EMB_VALID(ev), .EMB_OUTPUT(eo), .EMB_CHANNEL(ec),
        .EMB_SOURCE(es), .EMB_SAMPLE(esmp), .EMB_ORIGIN(eorg)
    );
    atsb_sink sink (
        .clk_sys(clk_sys), .rst(rst), .emb_valid(ev), .emb_output(eo),
        .emb_channel(ec), .emb_source(es), .emb_sample(esmp),
        .emb_origin(eorg)
    );
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_w(input atsb_word_t got, input atsb_word_t exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_s(input atsb_sample_t got, input atsb_sample_t exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: sample %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        miscompares++;
        $display("Error at %0t: no answer", $time);
        test_done();
    endtask
    function automatic atsb_word_t rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic atsb_addr_t ga(input int g, input int f);
        return 12'(g * 16 + f * 4);
    endfunction
    function automatic atsb_sample_t mag(input atsb_sample_t s);
        return s[23] ? -s : s;
    endfunction
    task automatic wr(input atsb_addr_t a, input atsb_word_t d,
                      input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
            if (n > 100) hang();
        end while (!bvalid);
        bready <= 1'b0;
        chk_w(32'(bresp), 32'(er));
    endtask
    task automatic rd(input atsb_addr_t a, output atsb_word_t d,
                      output logic [1:0] r);
        int n;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            n++;
            if (n > 100) hang();
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rd_chk(input atsb_addr_t a, input atsb_word_t e,
                          input logic [1:0] er);
        atsb_word_t d;
        logic [1:0] r;
        rd(a, d, r);
        chk_w(d, e);
        chk_w(32'(r), 32'(er));
    endtask
    // waits for k more compute-and-send passes to end; the first may be partial
    task automatic settle(input int k);
        int p;
        int n;
        p = sink.passes;
        n = 0;
        while (sink.passes < p + k) begin
            @(posedge clk_sys);
            n++;
            if (n > 200 * k) hang();
        end
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        atsb_word_t d;
        logic [1:0] r;
        int g;
        int f;
        seed = 32'hE4C813BC;
        for (int i = 0; i < 32; i++) freq[i] = 32'(`ATSB_FREQ_RST);
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            g = int'(rnd() % 32);
            rd_chk(ga(g, 0), 32'(`ATSB_FREQ_RST), OK);
            rd_chk(ga(g, 1), 32'(`ATSB_ATTEN_RST), OK);
            rd_chk(ga(g, 2), 32'(`ATSB_CTRL_RST), OK);
            rd_chk(ga(g, 3), `ATSB_ORIGIN_RST, OK);
            rd_chk(12'h200 + 12'(4 * g), 32'h0, OK);
        end
        wr(ga(5, 0), 32'h5, OK);
        rd_chk(ga(5, 0), 32'h14, OK);
        wr(ga(5, 0), 32'hFFFF, OK);
        rd_chk(ga(5, 0), 32'h9C40, OK);
        freq[5] = 32'h9C40;
        wr(ga(5, 1), 32'h3F, OK);
        rd_chk(ga(5, 1), 32'h3C, OK);
        for (int i = 0; i < 6; i++) begin
            g = int'(rnd() % 32);
            f = 20 + int'(rnd() % 39981);
            freq[g] = 32'(f);
            wr(ga(g, 0), 32'(f), OK);
            for (int h = 0; h < 32; h += 7) begin
                rd_chk(ga(h, 0), freq[h], OK);
            end
        end
        wr(12'h400, rnd(), ERR);
        rd_chk(12'h400, 32'h0, ERR);
        rd_chk(12'h308, 32'h0, ERR);
        // byte strobes merge into the word already held
        wstrb <= 4'h3;
        wr(ga(4, 3), 32'h41424344, OK);
        wstrb <= 4'hF;
        rd_chk(ga(4, 3), 32'h20204344, OK);
        for (int p = 0; p < 4; p++) begin
            wr(ga(6, 2), 32'(p * 4 + 2), OK);
            rd_chk(ga(6, 2), 32'(p * 4 + 2), OK);
        end
        // only four sources feed all channels, so sharing is certain
        for (int i = 0; i < 4; i++) begin
            wr(ga(i, 3), {8'h30 + 8'(i), 24'h304754}, OK);
        end
        for (int i = 0; i < 64; i++) begin
            route[i] = 2'(rnd());
            wr(12'h200 + 12'(4 * i), 32'(route[i]), OK);
        end
        settle(2);
        for (int i = 0; i < 64; i++) begin
            chk_w(32'(sink.src[i]), 32'(route[i]));
            chk_w(sink.org[i],
                  {8'h30 + 8'(route[i]), 24'h304754});
        end
        wr(ga(1, 2), 32'h1, OK);
        wr(ga(2, 1), 32'h3C, OK);
        settle(2);
        rd_chk(12'h300, 32'h2, OK);
        for (int i = 0; i < 64; i++) begin
            if (route[i] == 2'h1) chk_s(sink.smp[i], 24'h0);
            if (route[i] == route[0]) begin
                chk_s(sink.smp[i], sink.smp[0]);
            end
            if (route[i] == 2'h2) begin
                chk_w(32'(mag(sink.smp[i]) <= 24'h3FFF),
                      32'h1);
            end
        end
        wr(ga(3, 2), 32'hE, OK);
        settle(3);
        rd_chk(12'h300, 32'h2, OK);
        wr(ga(3, 2), 32'hF, OK);
        settle(2);
        rd_chk(12'h300, 32'hA, OK);
        wr(ga(3, 2), 32'h0, OK);
        settle(2);
        rd_chk(12'h300, 32'h2, OK);
        rd(12'h304, d, r);
        f = int'(d);
        // the first of four passes may have started before the read
        settle(4);
        rd(12'h304, d, r);
        chk_w(32'(d - 32'(f) >= 32'h3 &&
                  d - 32'(f) <= 32'h5), 32'h1);
        chk_w(32'(sink.bad), 32'h0);
        test_done();
    end
endmodule
